// ### bvs_pkg.sv
// constants, field layouts and carrier types of the buck voltage setting bank
// ============================================================================
// Notes on behaviour
// R1: read-only 7-bit ceiling code for regulator A, same coding as targets.
// R2: separate read-only 7-bit ceiling code for regulator B, same coding.
// R3: ceilings load from one-time storage; writes land only in test mode.
// R4: codes are linear: 0 is 0.30 V, 10 mV per step, 127 is 1.57 V.
// R5: A first setting: bit 7 low forces PWM, high selects auto; 6:0 target.
// R6: A second setting: bit 7 low forces PWM, high selects auto; 6:0 target.
// R7: B first setting: bit 7 low forces PWM, high selects auto; 6:0 target.
// R8: per-setting mode bits govern only while operating select is 00.
// R9: a target above the ceiling is limited to the ceiling code.
package bvs_pkg;

  localparam int          ADDR_W          = 9;
  localparam int          DATA_W          = 8;
  localparam int          CODE_W          = 7;
  localparam int          SEL_W           = 2;

  // ==========================================================================
  // register offsets
  localparam logic [8:0]  OFF_A_CEILING   = 9'h0d5;
  localparam logic [8:0]  OFF_B_CEILING   = 9'h0d6;
  localparam logic [8:0]  OFF_A_FIRST     = 9'h0d7;
  localparam logic [8:0]  OFF_A_SECOND    = 9'h0d8;
  localparam logic [8:0]  OFF_B_FIRST     = 9'h0d9;

  // ==========================================================================
  // field layout
  localparam int          AUTO_BIT        = 7;
  localparam logic [6:0]  CODE_MAX        = 7'h7f;
  localparam logic [7:0]  TARGET_RESET    = 8'h00;
  localparam logic [7:0]  READ_UNMAPPED   = 8'h00;

  // ==========================================================================
  // voltage coding, millivolts
  localparam int          VOLT_BASE_MV    = 300;
  localparam int          VOLT_STEP_MV    = 10;

  // operating select values
  localparam logic [1:0]  SEL_BY_SETTING  = 2'h0;
  localparam logic [1:0]  SEL_AUTO_ONE    = 2'h1;
  localparam logic [1:0]  SEL_FORCED_PWM  = 2'h2;
  localparam logic [1:0]  SEL_AUTO        = 2'h3;

  typedef struct packed {
    logic       auto_sel;
    logic [6:0] code;
  } bvs_setting_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [8:0] addr;
    logic [7:0] wdata;
  } bvs_req_t;

endpackage : bvs_pkg

// ### bvs_regs.sv
// register bank with voltage ceilings and targets of two buck regulators
`timescale 1ns/1ps
`default_nettype none
module bvs_regs
  import bvs_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire bvs_req_t         req,
  input  wire logic             test_mode,
  input  wire logic [6:0]       otp_a_ceiling,
  input  wire logic [6:0]       otp_b_ceiling,
  input  wire logic             reg_a_use_second,
  input  wire logic [1:0]       reg_a_operating_select,
  input  wire logic [1:0]       reg_b_operating_select,
  output logic      [7:0]       rdata,
  output logic                  rvalid,
  output logic      [6:0]       reg_a_applied_code,
  output logic                  reg_a_auto_mode,
  output logic      [6:0]       reg_b_applied_code,
  output logic                  reg_b_auto_mode
);

  // ==========================================================================
  // storage
  logic [6:0]       reg_a_ceiling_code;
  logic [6:0]       reg_b_ceiling_code;
  bvs_setting_t     reg_a_first_target;
  bvs_setting_t     reg_a_second_target;
  bvs_setting_t     reg_b_first_target;
  logic             loaded;

  // ==========================================================================
  // decode
  wire hit_ac = req.addr == OFF_A_CEILING;
  wire hit_bc = req.addr == OFF_B_CEILING;
  wire hit_a1 = req.addr == OFF_A_FIRST;
  wire hit_a2 = req.addr == OFF_A_SECOND;
  wire hit_b1 = req.addr == OFF_B_FIRST;
  wire ceil_wr_ok = req.wr && test_mode; // R3
  wire [7:0] read_mux =
      hit_ac ? {1'b0, reg_a_ceiling_code} :               // R1
      hit_bc ? {1'b0, reg_b_ceiling_code} :               // R2
      hit_a1 ? reg_a_first_target :
      hit_a2 ? reg_a_second_target :
      hit_b1 ? reg_b_first_target : READ_UNMAPPED;

  // ==========================================================================
  // active setting selection and ceiling clamp
  wire bvs_setting_t a_active = reg_a_use_second ? reg_a_second_target : reg_a_first_target;
  wire [6:0] next_a_code = (a_active.code > reg_a_ceiling_code) ?   // R9
                           reg_a_ceiling_code : a_active.code;      // R4
  wire [6:0] next_b_code = (reg_b_first_target.code > reg_b_ceiling_code) ? // R9
                           reg_b_ceiling_code : reg_b_first_target.code;
  // R5 R6 R8
  wire next_a_auto = (reg_a_operating_select == SEL_BY_SETTING) ? a_active.auto_sel :
                     (reg_a_operating_select != SEL_FORCED_PWM);
  // R7 R8
  wire next_b_auto = (reg_b_operating_select == SEL_BY_SETTING) ? reg_b_first_target.auto_sel :
                     (reg_b_operating_select != SEL_FORCED_PWM);

  // ==========================================================================
  // ceilings: loaded from one-time storage after reset release
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      loaded             <= 1'b0;
      reg_a_ceiling_code <= CODE_MAX;
      reg_b_ceiling_code <= CODE_MAX;
    end
    else if (!loaded)
    begin
      loaded             <= 1'b1;
      reg_a_ceiling_code <= otp_a_ceiling; // R3
      reg_b_ceiling_code <= otp_b_ceiling; // R3
    end
    else
    begin
      if (ceil_wr_ok && hit_ac)
        reg_a_ceiling_code <= req.wdata[6:0]; // R3
      if (ceil_wr_ok && hit_bc)
        reg_b_ceiling_code <= req.wdata[6:0]; // R3
    end
  end

  // ==========================================================================
  // targets
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      reg_a_first_target  <= TARGET_RESET;
      reg_a_second_target <= TARGET_RESET;
      reg_b_first_target  <= TARGET_RESET;
    end
    else if (req.wr)
    begin
      if (hit_a1)
        reg_a_first_target <= req.wdata;  // R5
      if (hit_a2)
        reg_a_second_target <= req.wdata; // R6
      if (hit_b1)
        reg_b_first_target <= req.wdata;  // R7
    end
  end

  // ==========================================================================
  // registered outputs
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rdata              <= READ_UNMAPPED;
      rvalid             <= 1'b0;
      reg_a_applied_code <= 7'h00;
      reg_b_applied_code <= 7'h00;
      reg_a_auto_mode    <= 1'b0;
      reg_b_auto_mode    <= 1'b0;
    end
    else
    begin
      rvalid             <= req.rd;
      rdata              <= req.rd ? read_mux : READ_UNMAPPED;
      reg_a_applied_code <= next_a_code;
      reg_b_applied_code <= next_b_code;
      reg_a_auto_mode    <= next_a_auto;
      reg_b_auto_mode    <= next_b_auto;
    end
  end

  // ==========================================================================
  // checks: ceilings
  a_ceiling_locked: assert property (@(posedge clk) disable iff (reset) // R3
    loaded && !test_mode && req.wr && hit_ac |=> $stable(reg_a_ceiling_code))
    else $error("ceiling A changed outside test mode");
  a_ceiling_b_lock: assert property (@(posedge clk) disable iff (reset) // R3
    loaded && !test_mode && req.wr && hit_bc |=> $stable(reg_b_ceiling_code))
    else $error("ceiling B changed outside test mode");
  a_ceiling_load: assert property (@(posedge clk) disable iff (reset) // R3
    !loaded |=> reg_a_ceiling_code == $past(otp_a_ceiling)
                && reg_b_ceiling_code == $past(otp_b_ceiling))
    else $error("ceiling not loaded from one-time storage");
  a_ceiling_write: assert property (@(posedge clk) disable iff (reset) // R3
    loaded && ceil_wr_ok && hit_ac |=> reg_a_ceiling_code == $past(req.wdata[6:0]))
    else $error("ceiling A test mode write lost");
  a_ceiling_b_write: assert property (@(posedge clk) disable iff (reset) // R3
    loaded && ceil_wr_ok && hit_bc |=> reg_b_ceiling_code == $past(req.wdata[6:0]))
    else $error("ceiling B test mode write lost");
  a_read_ceil_a: assert property (@(posedge clk) disable iff (reset) // R1
    req.rd && hit_ac && !req.wr |=> rvalid && rdata == {1'b0, $past(reg_a_ceiling_code)})
    else $error("ceiling A read mismatch");
  a_read_ceil_b: assert property (@(posedge clk) disable iff (reset) // R2
    req.rd && hit_bc && !req.wr |=> rvalid && rdata == {1'b0, $past(reg_b_ceiling_code)})
    else $error("ceiling B read mismatch");

  // ==========================================================================
  // checks: settings
  a_write_a1: assert property (@(posedge clk) disable iff (reset) // R5
    req.wr && hit_a1 |=> reg_a_first_target == $past(req.wdata))
    else $error("A first setting write lost");
  a_write_a2: assert property (@(posedge clk) disable iff (reset) // R6
    req.wr && hit_a2 |=> reg_a_second_target == $past(req.wdata))
    else $error("A second setting write lost");
  a_write_b1: assert property (@(posedge clk) disable iff (reset) // R7
    req.wr && hit_b1 |=> reg_b_first_target == $past(req.wdata))
    else $error("B first setting write lost");
  a_read_first_a: assert property (@(posedge clk) disable iff (reset) // R5
    req.rd && hit_a1 |=> rvalid && rdata == $past(reg_a_first_target))
    else $error("A first setting read mismatch");
  a_read_second_a: assert property (@(posedge clk) disable iff (reset) // R6
    req.rd && hit_a2 |=> rvalid && rdata == $past(reg_a_second_target))
    else $error("A second setting read mismatch");
  a_read_first_b: assert property (@(posedge clk) disable iff (reset) // R7
    req.rd && hit_b1 |=> rvalid && rdata == $past(reg_b_first_target))
    else $error("B first setting read mismatch");
  a_a_first_mode: assert property (@(posedge clk) disable iff (reset) // R5
    reg_a_operating_select == SEL_BY_SETTING && !reg_a_use_second
    |=> reg_a_auto_mode == $past(reg_a_first_target.auto_sel))
    else $error("A first setting mode wrong");
  a_a_second_mode: assert property (@(posedge clk) disable iff (reset) // R6
    reg_a_operating_select == SEL_BY_SETTING && reg_a_use_second
    |=> reg_a_auto_mode == $past(reg_a_second_target.auto_sel))
    else $error("A second setting mode wrong");
  a_b_first_mode: assert property (@(posedge clk) disable iff (reset) // R7
    reg_b_operating_select == SEL_BY_SETTING
    |=> reg_b_auto_mode == $past(reg_b_first_target.auto_sel))
    else $error("B first setting mode wrong");

  // ==========================================================================
  // checks: applied outputs
  a_clamp_a_code: assert property (@(posedge clk) disable iff (reset) // R9
    1'b1 |=> reg_a_applied_code <= $past(reg_a_ceiling_code))
    else $error("regulator A code above ceiling");
  a_clamp_b_code: assert property (@(posedge clk) disable iff (reset) // R9
    1'b1 |=> reg_b_applied_code <= $past(reg_b_ceiling_code))
    else $error("regulator B code above ceiling");
  a_unclamped_a: assert property (@(posedge clk) disable iff (reset) // R9
    a_active.code <= reg_a_ceiling_code |=> reg_a_applied_code == $past(a_active.code))
    else $error("regulator A code altered below ceiling");
  a_clamped_a: assert property (@(posedge clk) disable iff (reset) // R9
    a_active.code > reg_a_ceiling_code |=> reg_a_applied_code == $past(reg_a_ceiling_code))
    else $error("regulator A code not held at ceiling");
  a_unclamped_b: assert property (@(posedge clk) disable iff (reset) // R9
    reg_b_first_target.code <= reg_b_ceiling_code
    |=> reg_b_applied_code == $past(reg_b_first_target.code))
    else $error("regulator B code altered below ceiling");
  a_clamped_b: assert property (@(posedge clk) disable iff (reset) // R9
    reg_b_first_target.code > reg_b_ceiling_code
    |=> reg_b_applied_code == $past(reg_b_ceiling_code))
    else $error("regulator B code not held at ceiling");
  a_select_pwm: assert property (@(posedge clk) disable iff (reset) // R8
    reg_a_operating_select == SEL_FORCED_PWM ##1 reg_a_operating_select == SEL_FORCED_PWM
    |-> !reg_a_auto_mode)
    else $error("forced PWM overridden");
  a_b_forced_pwm: assert property (@(posedge clk) disable iff (reset) // R8
    reg_b_operating_select == SEL_FORCED_PWM |=> !reg_b_auto_mode)
    else $error("B forced PWM overridden");
  a_a_auto_select: assert property (@(posedge clk) disable iff (reset) // R8
    reg_a_operating_select == SEL_AUTO_ONE || reg_a_operating_select == SEL_AUTO
    |=> reg_a_auto_mode)
    else $error("A automatic select overridden");

  c_test_write: cover property (@(posedge clk) loaded && ceil_wr_ok && hit_ac);
  c_clamp_hit: cover property (@(posedge clk) a_active.code > reg_a_ceiling_code);
  c_second_set: cover property (@(posedge clk) reg_a_use_second && a_active.auto_sel);
  c_read_b1: cover property (@(posedge clk) req.rd && hit_b1);
  c_reload: cover property (@(posedge clk) !reset && !loaded);

endmodule // bvs_regs
`default_nettype wire

// ### tb_bvs_regs.sv
// self-checking testbench of the buck voltage setting register bank
`timescale 1ns/1ps
`default_nettype none
module tb_bvs_regs
  import bvs_pkg::*;
;
  logic       clk;
  logic       reset;
  logic       test_mode;
  logic       use2;
  bvs_req_t   req;
  logic [6:0] otp_a;
  logic [6:0] otp_b;
  logic [6:0] ceil_a;
  logic [6:0] ceil_b;
  logic [6:0] a_code;
  logic [6:0] b_code;
  logic [1:0] sel_a;
  logic [1:0] sel_b;
  logic [7:0] rdata;
  logic [7:0] d;
  logic       rvalid;
  logic       a_auto;
  logic       b_auto;
  logic [7:0] expq[$];
  int         err_total;
  int         check_count;
  integer     seed;
  int         n;

  bvs_regs i_bvs_regs (
    .clk(clk), .reset(reset), .req(req), .test_mode(test_mode),
    .otp_a_ceiling(otp_a), .otp_b_ceiling(otp_b), .reg_a_use_second(use2),
    .reg_a_operating_select(sel_a), .reg_b_operating_select(sel_b),
    .rdata(rdata), .rvalid(rvalid), .reg_a_applied_code(a_code),
    .reg_a_auto_mode(a_auto), .reg_b_applied_code(b_code), .reg_b_auto_mode(b_auto)
  );

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ==========================================================================
  // helpers
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic op(input logic w, input logic r, input logic [8:0] a, input logic [7:0] wd);
    @(negedge clk);
    req = '{w, r, a, wd};
  endtask

  task automatic idle;
    op(1'b0, 1'b0, 9'h000, 8'h00);
  endtask

  task automatic rd(input logic [8:0] a, input logic [7:0] e);
    op(1'b0, 1'b1, a, 8'h00);
    expq.push_back(e);
  endtask

  function automatic logic [6:0] lim(input logic [6:0] c, input logic [6:0] m);
    return (c > m) ? m : c;
  endfunction

  function automatic logic mode(input logic [1:0] s, input logic b);
    return (s == SEL_BY_SETTING) ? b : (s != SEL_FORCED_PWM);
  endfunction

  task automatic applied(input logic [6:0] ea, input logic ma, input logic [6:0] eb,
                         input logic mb);
    idle();
    idle();
    chk("a_code", {1'b0, ea}, {1'b0, a_code});
    chk("a_auto", {7'h00, ma}, {7'h00, a_auto});
    chk("b_code", {1'b0, eb}, {1'b0, b_code});
    chk("b_auto", {7'h00, mb}, {7'h00, b_auto});
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ==========================================================================
  // read result monitor
  always @(negedge clk)
    if (rvalid === 1'b1)
    begin
      if (expq.size() > 0)
        chk("rdata", expq.pop_front(), rdata);
      else
        chk("rvalid", 8'h00, 8'h01);
    end

  // ==========================================================================
  // main sequence
  initial
  begin
    seed = 32'h900277f3;
    req = '0;
    test_mode = 1'b0;
    use2 = 1'b0;
    sel_a = 2'h0;
    sel_b = 2'h0;
    otp_a = 7'($random(seed));
    otp_b = 7'($random(seed));
    reset = 1'b1;
    repeat (6) @(negedge clk);
    reset = 1'b0;
    idle();
    rd(OFF_A_CEILING, {1'b0, otp_a});
    rd(OFF_B_CEILING, {1'b0, otp_b});
    op(1'b1, 1'b0, OFF_A_CEILING, 8'h12);
    rd(OFF_A_CEILING, {1'b0, otp_a});
    test_mode = 1'b1;
    ceil_a = 7'h46;
    ceil_b = 7'($random(seed));
    op(1'b1, 1'b0, OFF_A_CEILING, {1'b1, ceil_a});
    op(1'b1, 1'b0, OFF_B_CEILING, {1'b1, ceil_b});
    rd(OFF_A_CEILING, {1'b0, ceil_a});
    rd(OFF_B_CEILING, {1'b0, ceil_b});
    test_mode = 1'b0;
    rd(9'h0da, READ_UNMAPPED);
    for (n = 0; n < 12; n++)
    begin
      d = 8'($random(seed));
      sel_a = n[1:0];
      sel_b = 2'(n + 1);
      use2 = n[2];
      op(1'b1, 1'b0, use2 ? OFF_A_SECOND : OFF_A_FIRST, d);
      op(1'b1, 1'b0, OFF_B_FIRST, ~d);
      rd(use2 ? OFF_A_SECOND : OFF_A_FIRST, d);
      rd(OFF_B_FIRST, ~d);
      applied(lim(d[6:0], ceil_a), mode(sel_a, d[7]),
              lim(~d[6:0], ceil_b), mode(sel_b, ~d[7]));
    end
    // mid-run reset: settings clear and ceilings reload from one-time storage
    reset = 1'b1;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    idle();
    rd(OFF_A_CEILING, {1'b0, otp_a});
    rd(OFF_B_CEILING, {1'b0, otp_b});
    rd(OFF_A_FIRST, TARGET_RESET);
    applied(7'h00, mode(sel_a, 1'b0), 7'h00, mode(sel_b, 1'b0));
    idle();
    for (n = 0; n < 10 && expq.size() > 0; n++)
      @(negedge clk);
    if (expq.size() > 0)
      err_total++;
    print_verdict();
  end
endmodule // tb_bvs_regs
`default_nettype wire
